// File: logic/icg_config.v
/*
 configuration logic of the internal clock generator: apb register file,
 mode selection, frequency setting and loss-of-lock / loss-of-clock requests.
 assumes: the analog oscillator, dco and reference report their state on
 synchronous inputs; frequencies are exchanged as kHz figures.
*/
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "icg_consts.vh"

module icg_config #(
    parameter FREQ_W = 32,
    parameter SETTLE_CYC = `ICG_MODE_SETTLE_CYC
) (
    // clock and reset
    input wire CLK,
    input wire RST,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // analog side status
    input wire [15:0] EXT_FREQ_KHZ,
    input wire [15:0] IRG_FREQ_KHZ,
    input wire LOCK_LOST,
    input wire CLOCK_LOST,
    input wire FLL_LOCKED,
    input wire DCO_STABLE,
    input wire STOP_MODE,
    // analog side control
    output reg [1:0] CLOCK_MODE,
    output reg [FREQ_W-1:0] GEN_FREQ_KHZ,
    output reg [FREQ_W-1:0] BUS_FREQ_KHZ,
    output reg [7:0] TRIM_VALUE,
    output reg OSC_ENABLE,
    output reg HIGH_GAIN,
    output reg CRYSTAL_REQ,
    output reg LOSS_CLK_DETECT_EN,
    output reg IRQ_REQ,
    output reg RESET_REQ
);

////////////////////////////////////////////////////////////////////////////////
// decode functions

// multiplication factor n = 4 + 2 * field
function [4:0] mult_factor;
    input [2:0] fld;
    begin
        mult_factor = `ICG_N_BASE + {1'b0, fld, 1'b0};
    end
endfunction

// reduction divisor is 2 ** field, applied as a right shift
function [FREQ_W-1:0] reduce;
    input [FREQ_W-1:0] f;
    input [2:0] fld;
    begin
        reduce = f >> fld;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// register state

reg [7:0] ctl1_r;
reg [7:0] ctl2_r;
reg [7:0] trim_r;
reg range_locked_r;
reg ext_locked_out_r;
reg mode_written_r;
reg [1:0] mode_r;
reg [7:0] settle_r;
reg flag_r;
reg lols_r;
reg locs_r;
reg pending_r;

wire apb_setup = PSEL & ~PENABLE;
wire apb_access = PSEL & PENABLE;
wire apb_done = apb_access & PREADY;
wire wr_en = apb_done & PWRITE;
wire hit_c1 = (PADDR == `ICG_OFS_CTL1);
wire hit_c2 = (PADDR == `ICG_OFS_CTL2);
wire hit_s1 = (PADDR == `ICG_OFS_STAT1);
wire hit_s2 = (PADDR == `ICG_OFS_STAT2);
wire hit_tr = (PADDR == `ICG_OFS_TRIM);
wire mapped = hit_c1 | hit_c2 | hit_s1 | hit_s2 | hit_tr;
wire [1:0] wr_mode = PWDATA[`ICG_C1_MODE_HI:`ICG_C1_MODE_LO];
wire busy = (settle_r != 8'h00);
// a mode write is still incomplete until the applied mode matches the field
wire mode_busy = pending_r | (ctl1_r[`ICG_C1_MODE_HI:`ICG_C1_MODE_LO] != mode_r);

////////////////////////////////////////////////////////////////////////////////
// apb slave: one wait state, so pready rises on the second access cycle
// unmapped offsets answer with an error, read as zero and leave every register alone

always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        PREADY <= 1'b0;
        PRDATA <= 32'h00000000;
        PSLVERR <= 1'b0;
    end
    else if (apb_access & ~PREADY)
    begin
        PREADY <= 1'b1;
        PSLVERR <= ~mapped;
        PRDATA <= 32'h00000000;
        if (~PWRITE)
        begin
            if (hit_c1)
                PRDATA <= {24'h000000, ctl1_r[7:1], 1'b0};
            else if (hit_c2)
                PRDATA <= {24'h000000, ctl2_r};
            else if (hit_s1)
                PRDATA <= {24'h000000, mode_r, 1'b0, lols_r, FLL_LOCKED, locs_r, 1'b0, flag_r};
            else if (hit_s2)
                PRDATA <= {24'h000000, 7'h00, DCO_STABLE};
            else if (hit_tr)
                PRDATA <= {24'h000000, trim_r};
        end
    end
    else
    begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        if (apb_setup)
            PRDATA <= 32'h00000000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// control registers
// trim only steers the internal reference; the frequency figures do not use it

always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        ctl1_r <= `ICG_CTL1_RST;
        ctl2_r <= `ICG_CTL2_RST;
        trim_r <= `ICG_TRIM_RST;
        range_locked_r <= 1'b0;
        ext_locked_out_r <= 1'b0;
        mode_written_r <= 1'b0;
    end
    else if (wr_en & hit_c1)
    begin
        ctl1_r[`ICG_C1_HGO] <= PWDATA[`ICG_C1_HGO];
        ctl1_r[`ICG_C1_OSCILLATOR_STOP_ENABLE] <= PWDATA[`ICG_C1_OSCILLATOR_STOP_ENABLE];
        ctl1_r[`ICG_C1_LOSS_OF_CLOCK_DISABLE] <= PWDATA[`ICG_C1_LOSS_OF_CLOCK_DISABLE];
        ctl1_r[`ICG_C1_RSVD] <= 1'b0;
        // range and reference select are write-once after reset
        if (~range_locked_r)
        begin
            ctl1_r[`ICG_C1_RANGE] <= PWDATA[`ICG_C1_RANGE];
            ctl1_r[`ICG_C1_EXTERNAL_REFERENCE_SELECT] <= PWDATA[`ICG_C1_EXTERNAL_REFERENCE_SELECT];
            range_locked_r <= 1'b1;
        end
        // a mode write during a pending switch is dropped
        if (~mode_busy & ~(ext_locked_out_r & wr_mode[1]))
        begin
            ctl1_r[`ICG_C1_MODE_HI:`ICG_C1_MODE_LO] <= wr_mode;
            mode_written_r <= 1'b1;
            // first mode write of 0x leaves the external pin unreserved
            if (~mode_written_r & ~wr_mode[1])
                ext_locked_out_r <= 1'b1;
        end
    end
    else if (wr_en & hit_c2)
    begin
        ctl2_r <= PWDATA[7:0];
    end
    else if (wr_en & hit_tr)
    begin
        trim_r <= PWDATA[7:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode switch: the applied mode follows the field after the settle time
// the settle count gives the analog side time to finish one switch before the next

always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        mode_r <= `ICG_MODE_SCM;
        settle_r <= 8'h00;
        pending_r <= 1'b0;
    end
    else if (busy)
    begin
        settle_r <= settle_r - 8'h01;
        if (settle_r == 8'h01)
        begin
            mode_r <= ctl1_r[`ICG_C1_MODE_HI:`ICG_C1_MODE_LO];
            pending_r <= 1'b0;
        end
    end
    else if (ctl1_r[`ICG_C1_MODE_HI:`ICG_C1_MODE_LO] != mode_r)
    begin
        settle_r <= SETTLE_CYC[7:0];
        pending_r <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// loss events: interrupt request or reset request
// the interrupt request stays up until software clears the flag; the reset request only follows the event

wire lol_evt = LOCK_LOST & ((mode_r == `ICG_MODE_FEI) | (mode_r == `ICG_MODE_FEE));
wire loc_evt = CLOCK_LOST & ~ctl1_r[`ICG_C1_LOSS_OF_CLOCK_DISABLE];
wire lol_irq = lol_evt & ~ctl2_r[`ICG_C2_LOCK_LOSS_RESET_ENABLE];
wire loc_irq = loc_evt & ~ctl2_r[`ICG_C2_CLOCK_LOSS_RESET_ENABLE];
wire flag_clr = wr_en & hit_s1 & PWDATA[`ICG_S1_FLAG];

always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        flag_r <= 1'b0;
        lols_r <= 1'b0;
        locs_r <= 1'b0;
        IRQ_REQ <= 1'b0;
        RESET_REQ <= 1'b0;
    end
    else
    begin
        // a new interrupt event (lol_irq or loc_irq) in the clearing cycle keeps the flag set
        if (lol_irq | loc_irq)
            flag_r <= 1'b1;
        else if (flag_clr)
            flag_r <= 1'b0;
        if (lol_evt)
            lols_r <= 1'b1;
        else if (flag_clr)
            lols_r <= 1'b0;
        if (loc_evt)
            locs_r <= 1'b1;
        else if (flag_clr)
            locs_r <= 1'b0;
        IRQ_REQ <= (lol_irq | loc_irq) | (flag_r & ~flag_clr);
        RESET_REQ <= (lol_evt & ctl2_r[`ICG_C2_LOCK_LOSS_RESET_ENABLE]) | (loc_evt & ctl2_r[`ICG_C2_CLOCK_LOSS_RESET_ENABLE]);
    end
end

////////////////////////////////////////////////////////////////////////////////
// frequency computation
// products are formed at FREQ_W bits; 16-bit references times 64 times 18 still fit

reg [FREQ_W-1:0] freq_nxt;
reg [FREQ_W-1:0] ref_khz;
reg [6:0] presc;

always @*
begin
    presc = ctl1_r[`ICG_C1_RANGE] ? `ICG_P_HIGH : `ICG_P_LOW;
    ref_khz = {{(FREQ_W-16){1'b0}}, EXT_FREQ_KHZ};
    freq_nxt = `ICG_SCM_KHZ;
    case (mode_r)
        `ICG_MODE_FEE:
        begin
            freq_nxt = reduce(ref_khz * presc * mult_factor(ctl2_r[`ICG_C2_MFD_HI:`ICG_C2_MFD_LO]),
                              ctl2_r[`ICG_C2_RFD_HI:`ICG_C2_RFD_LO]);
        end
        `ICG_MODE_FEI:
        begin
            // internal reference always uses the low-range prescale
            ref_khz = {{(FREQ_W-16){1'b0}}, IRG_FREQ_KHZ / `ICG_IRG_DIV};
            freq_nxt = reduce(ref_khz * `ICG_P_LOW * mult_factor(ctl2_r[`ICG_C2_MFD_HI:`ICG_C2_MFD_LO]),
                              ctl2_r[`ICG_C2_RFD_HI:`ICG_C2_RFD_LO]);
        end
        `ICG_MODE_FBE:
        begin
            freq_nxt = reduce(ref_khz, ctl2_r[`ICG_C2_RFD_HI:`ICG_C2_RFD_LO]);
        end
        default:
        begin
            freq_nxt = `ICG_SCM_KHZ;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs to the analog side
// every output leaves a flip-flop, so the analog side never sees decode glitches

always @(posedge CLK or posedge RST)
begin
    if (RST)
    begin
        CLOCK_MODE <= `ICG_MODE_SCM;
        GEN_FREQ_KHZ <= `ICG_SCM_KHZ;
        BUS_FREQ_KHZ <= `ICG_SCM_KHZ >> 1;
        TRIM_VALUE <= `ICG_TRIM_RST;
        OSC_ENABLE <= 1'b0;
        HIGH_GAIN <= 1'b0;
        CRYSTAL_REQ <= 1'b0;
        LOSS_CLK_DETECT_EN <= 1'b1;
    end
    else
    begin
        CLOCK_MODE <= mode_r;
        GEN_FREQ_KHZ <= freq_nxt;
        BUS_FREQ_KHZ <= freq_nxt >> 1;
        TRIM_VALUE <= trim_r;
        // oscillator runs in external modes, gated off in stop unless enabled
        OSC_ENABLE <= mode_r[1] & (~STOP_MODE | ctl1_r[`ICG_C1_OSCILLATOR_STOP_ENABLE]);
        HIGH_GAIN <= ctl1_r[`ICG_C1_HGO];
        CRYSTAL_REQ <= ctl1_r[`ICG_C1_EXTERNAL_REFERENCE_SELECT] & mode_r[1];
        LOSS_CLK_DETECT_EN <= ~ctl1_r[`ICG_C1_LOSS_OF_CLOCK_DISABLE];
    end
end

endmodule // icg_config

// File: logic/icg_consts.vh
/*
 constants of the clock generator configuration block: register offsets,
 field positions, reset values, decode tables and timing counts.
 assumes inclusion by bare name from the design files of this block.
*/
`ifndef ICG_CONSTS_VH
`define ICG_CONSTS_VH

// register byte offsets on the apb bus
`define ICG_OFS_CTL1 12'h000
`define ICG_OFS_CTL2 12'h004
`define ICG_OFS_STAT1 12'h008
`define ICG_OFS_STAT2 12'h00C
`define ICG_OFS_TRIM 12'h010

// clock_control_one fields
`define ICG_C1_HGO 7
`define ICG_C1_RANGE 6
`define ICG_C1_EXTERNAL_REFERENCE_SELECT 5
`define ICG_C1_MODE_HI 4
`define ICG_C1_MODE_LO 3
`define ICG_C1_OSCILLATOR_STOP_ENABLE 2
`define ICG_C1_LOSS_OF_CLOCK_DISABLE 1
`define ICG_C1_RSVD 0

// clock_control_two fields
`define ICG_C2_LOCK_LOSS_RESET_ENABLE 7
`define ICG_C2_MFD_HI 6
`define ICG_C2_MFD_LO 4
`define ICG_C2_CLOCK_LOSS_RESET_ENABLE 3
`define ICG_C2_RFD_HI 2
`define ICG_C2_RFD_LO 0

// first and second status register fields
`define ICG_S1_MODE_HI 7
`define ICG_S1_MODE_LO 6
`define ICG_S1_LOLS 4
`define ICG_S1_LOCK 3
`define ICG_S1_LOCS 2
`define ICG_S1_FLAG 0
`define ICG_S2_OSCILLATOR_STABLE_FLAG 0

// clock modes
`define ICG_MODE_SCM 2'h0
`define ICG_MODE_FEI 2'h1
`define ICG_MODE_FBE 2'h2
`define ICG_MODE_FEE 2'h3

// reset values
`define ICG_CTL1_RST 8'h00
`define ICG_CTL2_RST 8'h00
`define ICG_TRIM_RST 8'h80

// prescale, reference divider, multiplier base
`define ICG_P_LOW 7'h40
`define ICG_P_HIGH 7'h01
`define ICG_IRG_DIV 16'h0007
`define ICG_N_BASE 5'h04
`define ICG_SCM_KHZ 32'h00001F40

// timing: mode switch settle time in ns, clock period in ns
`define ICG_CLK_PERIOD_NS 100
`define ICG_MODE_SETTLE_NS 800
`define ICG_MODE_SETTLE_CYC ((`ICG_MODE_SETTLE_NS + `ICG_CLK_PERIOD_NS - 1) / `ICG_CLK_PERIOD_NS)

`endif

// File: testbench/icg_config_chk.sv
/*
 assertion checker for the clock generator configuration block.
 assumes a bind onto icg_config, every input named as the port it watches.
*/
`timescale 1ns/100ps
module icg_chk #(
    parameter FREQ_W = 32
) (
    // clock and reset
    input wire CLK,
    input wire RST,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    // status side
    input wire LOCK_LOST,
    input wire CLOCK_LOST,
    input wire [1:0] CLOCK_MODE,
    input wire [FREQ_W-1:0] GEN_FREQ_KHZ,
    input wire [FREQ_W-1:0] BUS_FREQ_KHZ,
    input wire LOSS_CLK_DETECT_EN,
    input wire IRQ_REQ,
    input wire RESET_REQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    a_apb_answer: assert property (s_setup ##1 s_access |=> PREADY)
        else $error("access phase not two cycles");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (PREADY && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > 12'h010))
        else $error("error response wrong");
    a_ctl1_bit0: assert property (PREADY && !PWRITE && PADDR == 12'h000 |-> PRDATA[0] == 1'b0)
        else $error("control one bit 0 not zero");
    // frequency lags its cause by one edge, so wait for two stable samples
    a_bus_half: assert property ($stable(GEN_FREQ_KHZ) [*2] |-> BUS_FREQ_KHZ == GEN_FREQ_KHZ >> 1)
        else $error("bus rate not half");
    a_scm_freq: assert property (CLOCK_MODE == 2'h0 [*2] |-> GEN_FREQ_KHZ == 32'h00001F40)
        else $error("self-clocked rate wrong");
    a_lock_irq: assert property (LOCK_LOST && CLOCK_MODE[0] |=> IRQ_REQ || RESET_REQ)
        else $error("lock loss not reported");
    a_clk_irq: assert property (CLOCK_LOST && LOSS_CLK_DETECT_EN |=> IRQ_REQ || RESET_REQ)
        else $error("clock loss not reported");
    a_reset_cause: assert property (RESET_REQ |-> $past(LOCK_LOST || CLOCK_LOST))
        else $error("reset request without event");
endmodule // icg_chk

// File: testbench/tb.sv
/*
 self-checking bench for the clock generator configuration block.
 assumes the design, its header and the checker are compiled first.
*/
`timescale 1ns/100ps
`include "icg_consts.vh"
module tb;
    reg CLK, RST, PSEL, PENABLE, PWRITE;
    reg [11:0] PADDR;
    reg [31:0] PWDATA;
    reg [15:0] EXT_FREQ_KHZ, IRG_FREQ_KHZ;
    reg LOCK_LOST, CLOCK_LOST, FLL_LOCKED, DCO_STABLE, STOP_MODE;
    wire [31:0] PRDATA, GEN_FREQ_KHZ, BUS_FREQ_KHZ;
    wire [1:0] CLOCK_MODE;
    wire [7:0] TRIM_VALUE;
    wire PREADY, PSLVERR, OSC_ENABLE, HIGH_GAIN, CRYSTAL_REQ, LOSS_CLK_DETECT_EN, IRQ_REQ, RESET_REQ;
    integer err_count, tests_run, r, k, e;
    reg [31:0] rd, t;
    reg [7:0] c1;
    reg [2:0] mf, rf;
    reg er;
    icg_config #(.FREQ_W(32), .SETTLE_CYC(8)) i_dut (
        .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EXT_FREQ_KHZ(EXT_FREQ_KHZ), .IRG_FREQ_KHZ(IRG_FREQ_KHZ), .LOCK_LOST(LOCK_LOST),
        .CLOCK_LOST(CLOCK_LOST), .FLL_LOCKED(FLL_LOCKED), .DCO_STABLE(DCO_STABLE), .STOP_MODE(STOP_MODE),
        .CLOCK_MODE(CLOCK_MODE), .GEN_FREQ_KHZ(GEN_FREQ_KHZ), .BUS_FREQ_KHZ(BUS_FREQ_KHZ),
        .TRIM_VALUE(TRIM_VALUE), .OSC_ENABLE(OSC_ENABLE), .HIGH_GAIN(HIGH_GAIN), .CRYSTAL_REQ(CRYSTAL_REQ),
        .LOSS_CLK_DETECT_EN(LOSS_CLK_DETECT_EN), .IRQ_REQ(IRQ_REQ), .RESET_REQ(RESET_REQ)
    );
    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    ////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle edge before each setup keeps every signal to one change per step
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK);
            n = n + 1;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (n == 20)
            err_count = err_count + 1;
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task rchk(input [11:0] a, input [31:0] m, input [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd & m, x);
    endtask
    task ev(input integer which);
        {LOCK_LOST, CLOCK_LOST} <= which ? 2'h1 : 2'h2;
        @(posedge CLK);
        {LOCK_LOST, CLOCK_LOST} <= 2'h0;
        @(posedge CLK);
    endtask
    function [31:0] efreq(input [1:0] m, input rg, input [2:0] f, input [2:0] s);
        reg [31:0] n;
        n = 32'h4 + 32'h2 * f;
        if (m == 2'h3)
            efreq = (EXT_FREQ_KHZ * (rg ? 32'h1 : 32'h40) * n) >> s;
        else
            efreq = ((IRG_FREQ_KHZ / 32'h7) * 32'h40 * n) >> s;
    endfunction
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        err_count = 0;
        tests_run = 0;
        {PSEL, PENABLE, PWRITE, LOCK_LOST, CLOCK_LOST, STOP_MODE} = 6'h00;
        {PADDR, PWDATA} = 44'h0;
        rd = $urandom(52029);
        // second pass resets mid-run to reach the other range setting
        for (r = 0; r < 2; r = r + 1)
        begin
            RST <= 1'b1;
            rd = $urandom;
            {EXT_FREQ_KHZ, IRG_FREQ_KHZ} <= $urandom;
            FLL_LOCKED <= rd[0];
            DCO_STABLE <= rd[1];
            c1 = {rd[2], r[0], 1'b1, 2'h3, 2'h0, 1'b1};
            repeat (20) @(posedge CLK);
            RST <= 1'b0;
            chk(GEN_FREQ_KHZ, 32'h00001F40);
            chk(BUS_FREQ_KHZ, 32'h00000FA0);
            rchk(`ICG_OFS_TRIM, 32'hFFFFFFFF, 32'h00000080);
            rchk(`ICG_OFS_CTL2, 32'hFFFFFFFF, 32'h0);
            apb(1'b1, `ICG_OFS_CTL1, {24'h0, c1});
            apb(1'b1, `ICG_OFS_CTL1, {24'h0, c1 ^ 8'h60});
            rchk(`ICG_OFS_CTL1, 32'hFFFFFFFF, {24'h0, c1 & 8'hFE});
            chk(HIGH_GAIN, c1[7]);
            for (k = 0; k < 4; k = k + 1)
            begin
                rd = $urandom;
                {mf, rf} = (k == 0) ? 6'h18 : (k == 1) ? 6'h01 : rd[5:0];
                apb(1'b1, `ICG_OFS_CTL2, {24'h0, r[0], mf, r[0], rf});
                repeat (12) @(posedge CLK);
                chk(CLOCK_MODE, 2'h3);
                chk(GEN_FREQ_KHZ, efreq(2'h3, r[0], mf, rf));
                chk(BUS_FREQ_KHZ, efreq(2'h3, r[0], mf, rf) >> 1);
                chk(CRYSTAL_REQ, 1'b1);
            end
            STOP_MODE <= 1'b1;
            repeat (2) @(posedge CLK);
            chk(OSC_ENABLE, 1'b0);
            STOP_MODE <= 1'b0;
            repeat (2) @(posedge CLK);
            chk(OSC_ENABLE, 1'b1);
            apb(1'b1, `ICG_OFS_CTL1, {24'h0, c1 ^ 8'h10});
            apb(1'b1, `ICG_OFS_CTL1, {24'h0, c1});
            repeat (12) @(posedge CLK);
            chk(CLOCK_MODE, 2'h1);
            chk(GEN_FREQ_KHZ, efreq(2'h1, r[0], mf, rf));
            chk(CRYSTAL_REQ, 1'b0);
            for (e = 0; e < 2; e = e + 1)
            begin
                ev(e);
                chk(RESET_REQ, r);
                chk(IRQ_REQ, !r);
                if (r == 0)
                begin
                    rchk(`ICG_OFS_STAT1, 32'h15, e ? 32'h05 : 32'h11);
                    apb(1'b1, `ICG_OFS_STAT1, 32'hFF);
                    rchk(`ICG_OFS_STAT1, 32'hDD, {24'h0, 2'h1, 2'h0, FLL_LOCKED, 3'h0});
                    chk(IRQ_REQ, 1'b0);
                end
            end
            // trim with the divisor doubled so the output cannot overshoot, then restore it
            rf = rf & 3'h6;
            apb(1'b1, `ICG_OFS_CTL2, {24'h0, r[0], mf, r[0], rf | 3'h1});
            t = $urandom;
            apb(1'b1, `ICG_OFS_TRIM, t);
            repeat (2) @(posedge CLK);
            chk(TRIM_VALUE, t[7:0]);
            chk(GEN_FREQ_KHZ, efreq(2'h1, r[0], mf, rf | 3'h1));
            apb(1'b1, `ICG_OFS_CTL2, {24'h0, r[0], mf, r[0], rf});
            repeat (2) @(posedge CLK);
            chk(GEN_FREQ_KHZ, efreq(2'h1, r[0], mf, rf));
            chk(BUS_FREQ_KHZ, efreq(2'h1, r[0], mf, rf) >> 1);
            // bypassed external mode: reference straight through the divisor
            apb(1'b1, `ICG_OFS_CTL1, {24'h0, c1 ^ 8'h08});
            repeat (12) @(posedge CLK);
            chk(CLOCK_MODE, 2'h2);
            chk(GEN_FREQ_KHZ, {16'h0, EXT_FREQ_KHZ} >> rf);
            chk(OSC_ENABLE, 1'b1);
            chk(CRYSTAL_REQ, 1'b1);
            chk(LOSS_CLK_DETECT_EN, 1'b1);
            rchk(`ICG_OFS_STAT2, 32'h1, DCO_STABLE);
            apb(1'b0, 12'h020, 32'h0);
            chk({31'h0, er}, 32'h1);
            chk(rd, 32'h0);
            $display("pass %0d done", r);
        end
        end_sim;
    end
    initial
    begin
        #2000000;
        err_count = err_count + 1;
        end_sim;
    end
endmodule // tb
bind icg_config icg_chk #(.FREQ_W(FREQ_W)) i_chk (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LOCK_LOST(LOCK_LOST), .CLOCK_LOST(CLOCK_LOST),
    .CLOCK_MODE(CLOCK_MODE), .GEN_FREQ_KHZ(GEN_FREQ_KHZ), .BUS_FREQ_KHZ(BUS_FREQ_KHZ),
    .LOSS_CLK_DETECT_EN(LOSS_CLK_DETECT_EN), .IRQ_REQ(IRQ_REQ), .RESET_REQ(RESET_REQ)
);
